// file: src/clm_consts.svh
`ifndef CLM_CONSTS_SVH
`define CLM_CONSTS_SVH

// ==========================================================================
// Register byte offsets
`define CLM_OFF_CTRL     12'h000
`define CLM_OFF_OPA      12'h004
`define CLM_OFF_OPB      12'h008
`define CLM_OFF_INSTR    12'h00c
`define CLM_OFF_RESULT   12'h010
`define CLM_OFF_EA       12'h014
`define CLM_OFF_STATUS   12'h018
`define CLM_OFF_MASK     12'h01c
`define CLM_OFF_DSISR    12'h020

// ==========================================================================
// Field positions
`define CLM_CTRL_DR      0
`define CLM_CTRL_IR      1
`define CLM_CTRL_IOSEG   4
`define CLM_ST_DONE      0
`define CLM_ST_DSI       1
`define CLM_ST_MCK       2
`define CLM_ST_BUSY      8
`define CLM_DSISR_FIRST  31

// ==========================================================================
// Reset values
`define CLM_RST_WORD     32'h0000_0000
`define CLM_RST_MASK     3'h0

// ==========================================================================
// Instruction encodings and line size limits
`define CLM_OP_PRIMARY   6'h1f
`define CLM_XO_QUERY     10'h213
`define CLM_XO_FLUSH     10'h076
`define CLM_SEL_ICACHE   5'h0c
`define CLM_SEL_DCACHE   5'h0d
`define CLM_SEL_MIN      5'h0e
`define CLM_SEL_MAX      5'h0f
`define CLM_LINE_MIN     32'h0000_0040
`define CLM_LINE_MAX     32'h0000_1000

`endif

// file: src/clm_pkg.sv
package clm_pkg;

    // ======================================================================
    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_EXEC   = 4'h2,
        ST_XLATE  = 4'h4,
        ST_LOOKUP = 4'h8
    } fsm_type;

    // Instruction word, bit 0 of the format is the msb
    typedef struct packed {
        logic [5:0] op;
        logic [4:0] target_reg_field;
        logic [4:0] base_reg_field;
        logic [4:0] index_reg_field;
        logic [9:0] xo;
        logic       record_bit;
    } instr_type;

    typedef struct packed {
        logic        ack;
        logic        valid;
        logic        tlb_miss;
        logic        real_bad;
        logic [31:0] raddr;
    } xlate_rsp_type;

    typedef struct packed {
        logic ack;
        logic dc_hit;
        logic dc_dirty;
        logic ic_hit;
    } cache_rsp_type;

    typedef struct packed {
        fsm_type     st;
        logic        data_relocate_bit;
        logic        instr_relocate_bit;
        logic [3:0]  io_seg;
        logic [31:0] opa;
        logic [31:0] opb;
        logic [31:0] instr;
        logic [31:0] result;
        logic [31:0] ea;
        logic [31:0] raddr;
        logic        xl_bad;
        logic [2:0]  stat;
        logic [2:0]  mask;
        logic [31:0] dsisr;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic        xl_req;
        logic        xl_load;
        logic        lk_req;
        logic        wb_go;
        logic        inv_go;
        logic        ref_go;
        logic        gpr_we;
        logic [4:0]  gpr_idx;
        logic [31:0] gpr_data;
    } state_type;

endpackage : clm_pkg

// file: src/line_size_query.sv
`timescale 1ns/10ps
`default_nettype none
`include "clm_consts.svh"

module line_size_query #(
    parameter logic [31:0] ILINE = 32'h0000_0080,
    parameter logic [31:0] DLINE = 32'h0000_0040
) (
    input  wire logic [4:0]  i_sel,
    output logic      [31:0] o_size
);
    // Keep every reported size inside the legal window
    function automatic logic [31:0] clamp(input logic [31:0] v);
        if (v < `CLM_LINE_MIN) begin
            return `CLM_LINE_MIN;
        end
        if (v > `CLM_LINE_MAX) begin
            return `CLM_LINE_MAX;
        end
        return v;
    endfunction : clamp

    logic [31:0] ic;
    logic [31:0] dc;
    assign ic = clamp(ILINE);
    assign dc = clamp(DLINE);

    always_comb begin
        case (i_sel)
            `CLM_SEL_ICACHE: o_size = ic;
            `CLM_SEL_DCACHE: o_size = dc;
            `CLM_SEL_MIN:    o_size = (ic < dc) ? ic : dc;
            `CLM_SEL_MAX:    o_size = (ic > dc) ? ic : dc;
            default:         o_size = `CLM_RST_WORD;
        endcase
    end
endmodule : line_size_query
`default_nettype wire

// file: src/flush_addr_gen.sv
`timescale 1ns/10ps
`default_nettype none

module flush_addr_gen (
    input  wire logic [4:0]  i_base_field,
    input  wire logic [31:0] i_opa,
    input  wire logic [31:0] i_opb,
    input  wire logic [3:0]  i_io_seg,
    output logic      [31:0] o_ea,
    output logic             o_io
);
    // A zero base field means a literal zero, not the register contents
    assign o_ea = ((i_base_field == 5'h00) ? 32'h0000_0000 : i_opa) + i_opb;
    // The top nibble selects the I/O segment
    assign o_io = (o_ea[31:28] == i_io_seg);
endmodule : flush_addr_gen
`default_nettype wire

// file: src/cache_line_maint.sv
// What this block does
// R1: Decode size query: op 31, xo 531
// R2: Selectors 01100-01111 give I, D, min, max
// R3: Other selectors give a zero result
// R4: Reported sizes stay within 64..4096
// R5: Query leaves exception register untouched
// R6: Decode flush: op 31, xo 118
// R7: Address is base plus index, zero base
// R8: Nonzero base gets address back unless fault
// R9: Relocation off: address used as real
// R10: Relocation on: translate, ignore instruction relocation
// R11: Modified data line starts its write-back
// R12: Line present in either cache is invalidated
// R13: No translation raises storage fault, sets bit
// R14: Bad real address with data hit: machine check
// R15: Translate as a load, no protection checks
// R16: Look-aside miss sets the reference bit
// R17: I/O address: no cache action, base written
// R18: Flush leaves exception register untouched
// R19: Software flushes, syncs, then refetches code
`timescale 1ns/10ps
`default_nettype none
`include "clm_consts.svh"

module cache_line_maint #(
    parameter logic [31:0] ILINE = 32'h0000_0080,
    parameter logic [31:0] DLINE = 32'h0000_0040
) (
    input  wire logic                   i_mclk,
    input  wire logic                   i_rst,
    input  wire logic                   i_psel,
    input  wire logic                   i_penable,
    input  wire logic                   i_pwrite,
    input  wire logic [11:0]            i_paddr,
    input  wire logic [31:0]            i_pwdata,
    output logic      [31:0]            o_prdata,
    output logic                        o_pready,
    output logic                        o_pslverr,
    output logic                        o_irq,
    output logic                        o_xl_req,
    output logic                        o_xl_load,
    output logic      [31:0]            o_xl_addr,
    input  wire clm_pkg::xlate_rsp_type i_xl,
    output logic                        o_lk_req,
    output logic      [31:0]            o_lk_addr,
    input  wire clm_pkg::cache_rsp_type i_lk,
    output logic                        o_wb_start,
    output logic                        o_inval,
    output logic                        o_ref_set,
    output logic                        o_gpr_we,
    output logic      [4:0]             o_gpr_idx,
    output logic      [31:0]            o_gpr_data
);
    // ======================================================================
    // Helpers
    function automatic clm_pkg::instr_type decode(input logic [31:0] w);
        return clm_pkg::instr_type'(w);
    endfunction : decode

    function automatic logic is_mapped(input logic [11:0] a);
        case (a)
            `CLM_OFF_CTRL, `CLM_OFF_OPA, `CLM_OFF_OPB, `CLM_OFF_INSTR,
            `CLM_OFF_RESULT, `CLM_OFF_EA, `CLM_OFF_STATUS, `CLM_OFF_MASK,
            `CLM_OFF_DSISR: return 1'b1;
            default:        return 1'b0;
        endcase
    endfunction : is_mapped

    clm_pkg::state_type s;
    clm_pkg::state_type n;
    clm_pkg::instr_type ins;
    logic [31:0]        qsize;
    logic [31:0]        ea_c;
    logic               io_c;
    logic               setup;
    logic               wr;
    logic               is_query;
    logic               is_flush;
    logic               base_nz;
    logic [2:0]         ev;
    logic [2:0]         w1c;
    logic [31:0]        rd_v;

    assign ins      = decode(s.instr);
    assign is_query = (ins.op == `CLM_OP_PRIMARY) && (ins.xo == `CLM_XO_QUERY); // [R1]
    assign is_flush = (ins.op == `CLM_OP_PRIMARY) && (ins.xo == `CLM_XO_FLUSH); // [R6]
    assign base_nz  = (ins.base_reg_field != 5'h00);
    assign setup    = i_psel & ~i_penable;
    assign wr       = i_psel & i_penable & s.pready & i_pwrite;

    line_size_query #(
        .ILINE (ILINE),
        .DLINE (DLINE)
    ) u_query (
        .i_sel  (ins.base_reg_field),
        .o_size (qsize)
    );

    flush_addr_gen u_addr (
        .i_base_field (ins.base_reg_field),
        .i_opa        (s.opa),
        .i_opb        (s.opb),
        .i_io_seg     (s.io_seg),
        .o_ea         (ea_c),
        .o_io         (io_c)
    );

    // ======================================================================
    // Next state
    always_comb begin
        n        = s;
        ev       = 3'h0;
        w1c      = 3'h0;
        n.wb_go  = 1'b0;
        n.inv_go = 1'b0;
        n.ref_go = 1'b0;
        n.gpr_we = 1'b0;

        // Read data is captured in the setup cycle so the port comes off a flop
        case (i_paddr)
            `CLM_OFF_CTRL:   rd_v = {24'h000000, s.io_seg, 2'h0,
                                     s.instr_relocate_bit, s.data_relocate_bit};
            `CLM_OFF_OPA:    rd_v = s.opa;
            `CLM_OFF_OPB:    rd_v = s.opb;
            `CLM_OFF_INSTR:  rd_v = s.instr;
            `CLM_OFF_RESULT: rd_v = s.result;
            `CLM_OFF_EA:     rd_v = s.ea;
            `CLM_OFF_STATUS: rd_v = {23'h000000, (s.st != clm_pkg::ST_IDLE),
                                     5'h00, s.stat};
            `CLM_OFF_MASK:   rd_v = {29'h00000000, s.mask};
            `CLM_OFF_DSISR:  rd_v = s.dsisr;
            default:         rd_v = `CLM_RST_WORD;
        endcase
        n.pready  = setup;
        n.pslverr = setup & ~is_mapped(i_paddr);
        if (setup) begin
            n.prdata = rd_v;
        end

        if (wr) begin
            case (i_paddr)
                `CLM_OFF_CTRL: begin
                    n.data_relocate_bit  = i_pwdata[`CLM_CTRL_DR];
                    n.instr_relocate_bit = i_pwdata[`CLM_CTRL_IR];
                    n.io_seg             = i_pwdata[`CLM_CTRL_IOSEG +: 4];
                end
                `CLM_OFF_OPA:    n.opa = i_pwdata;
                `CLM_OFF_OPB:    n.opb = i_pwdata;
                `CLM_OFF_STATUS: w1c = i_pwdata[2:0];
                `CLM_OFF_MASK:   n.mask = i_pwdata[2:0];
                `CLM_OFF_DSISR:  n.dsisr = i_pwdata;
                default: begin
                end
            endcase
        end

        case (s.st)
            clm_pkg::ST_IDLE: begin
                // A new instruction while one is running is dropped
                if (wr && (i_paddr == `CLM_OFF_INSTR)) begin
                    n.instr = i_pwdata;
                    n.st    = clm_pkg::ST_EXEC;
                end
            end
            clm_pkg::ST_EXEC: begin
                n.st = clm_pkg::ST_IDLE;
                // No exception register or condition field is touched here
                if (is_query) begin // [R5]
                    n.result   = qsize; // [R2] [R3] [R4]
                    n.gpr_we   = 1'b1;
                    n.gpr_idx  = ins.target_reg_field;
                    n.gpr_data = qsize;
                    ev[`CLM_ST_DONE] = 1'b1;
                end else if (is_flush) begin // [R18]
                    n.ea     = ea_c; // [R7]
                    n.xl_bad = 1'b0;
                    if (io_c) begin
                        // I/O space: nothing reaches the caches or memory
                        n.gpr_we   = base_nz; // [R17]
                        n.gpr_idx  = ins.base_reg_field;
                        n.gpr_data = ea_c;
                        ev[`CLM_ST_DONE] = 1'b1;
                    end else if (s.data_relocate_bit) begin
                        n.xl_req  = 1'b1; // [R10]
                        n.xl_load = 1'b1; // [R15]
                        n.st      = clm_pkg::ST_XLATE;
                    end else begin
                        n.raddr  = ea_c; // [R9]
                        n.lk_req = 1'b1;
                        n.st     = clm_pkg::ST_LOOKUP;
                    end
                end else begin
                    ev[`CLM_ST_DONE] = 1'b1;
                end
            end
            clm_pkg::ST_XLATE: begin
                if (i_xl.ack) begin
                    n.xl_req  = 1'b0;
                    n.xl_load = 1'b0;
                    if (!i_xl.valid) begin
                        // Faulted: the base register keeps its old value
                        n.dsisr[`CLM_DSISR_FIRST] = 1'b1; // [R13]
                        ev[`CLM_ST_DSI]  = 1'b1;
                        ev[`CLM_ST_DONE] = 1'b1;
                        n.st             = clm_pkg::ST_IDLE;
                    end else begin
                        n.raddr  = i_xl.raddr;
                        n.xl_bad = i_xl.real_bad;
                        n.ref_go = i_xl.tlb_miss; // [R16]
                        n.lk_req = 1'b1;
                        n.st     = clm_pkg::ST_LOOKUP;
                    end
                end
            end
            clm_pkg::ST_LOOKUP: begin
                if (i_lk.ack) begin
                    n.lk_req = 1'b0;
                    n.st     = clm_pkg::ST_IDLE;
                    if (s.xl_bad && i_lk.dc_hit) begin
                        ev[`CLM_ST_MCK] = 1'b1; // [R14]
                    end else begin
                        n.wb_go  = i_lk.dc_hit & i_lk.dc_dirty; // [R11]
                        n.inv_go = i_lk.dc_hit | i_lk.ic_hit; // [R12]
                    end
                    n.gpr_we   = base_nz; // [R8]
                    n.gpr_idx  = ins.base_reg_field;
                    n.gpr_data = s.ea;
                    ev[`CLM_ST_DONE] = 1'b1;
                end
            end
            default: begin
                n.st = clm_pkg::ST_IDLE;
            end
        endcase

        // A new event beats a clear in the same cycle
        n.stat = (s.stat & ~w1c) | ev;
        n.irq  = |(n.stat & n.mask);
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            s      <= '0;
            s.st   <= clm_pkg::ST_IDLE;
            s.mask <= `CLM_RST_MASK;
        end else begin
            s <= n;
        end
    end

    // ======================================================================
    // Outputs
    assign o_prdata   = s.prdata;
    assign o_pready   = s.pready;
    assign o_pslverr  = s.pslverr;
    assign o_irq      = s.irq;
    assign o_xl_req   = s.xl_req;
    assign o_xl_load  = s.xl_load;
    assign o_xl_addr  = s.ea;
    assign o_lk_req   = s.lk_req;
    assign o_lk_addr  = s.raddr;
    assign o_wb_start = s.wb_go;
    assign o_inval    = s.inv_go;
    assign o_ref_set  = s.ref_go;
    assign o_gpr_we   = s.gpr_we;
    assign o_gpr_idx  = s.gpr_idx;
    assign o_gpr_data = s.gpr_data;

    // ======================================================================
    // Checks
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    sequence exec_query_s;
        (s.st == clm_pkg::ST_EXEC) && is_query;
    endsequence
    sequence exec_flush_s;
        (s.st == clm_pkg::ST_EXEC) && is_flush && !io_c;
    endsequence
    sequence xl_fault_s;
        (s.st == clm_pkg::ST_XLATE) && i_xl.ack && !i_xl.valid;
    endsequence
    sequence lk_done_s;
        (s.st == clm_pkg::ST_LOOKUP) && i_lk.ack;
    endsequence

    query_decode_a : assert property ( // [R1]
        exec_query_s |=> o_gpr_we && (o_gpr_idx == $past(ins.target_reg_field)))
        else $error("size query did not write its target register");
    dcache_size_a : assert property ( // [R2]
        exec_query_s ##0 (ins.base_reg_field == `CLM_SEL_DCACHE)
        |=> o_gpr_data == DLINE)
        else $error("data cache line size wrong");
    size_window_a : assert property ( // [R4]
        exec_query_s ##0 (ins.base_reg_field[4:2] == 3'h3)
        |=> (o_gpr_data >= `CLM_LINE_MIN) && (o_gpr_data <= `CLM_LINE_MAX))
        else $error("reported line size outside window");
    ea_form_a : assert property ( // [R7]
        (s.st == clm_pkg::ST_EXEC) && is_flush
        |=> s.ea == (($past(base_nz) ? $past(s.opa) : 32'h0000_0000) + $past(s.opb)))
        else $error("flush effective address wrong");
    real_path_a : assert property ( // [R9]
        exec_flush_s ##0 !s.data_relocate_bit
        |=> o_lk_req && !o_xl_req && (o_lk_addr == o_xl_addr))
        else $error("unrelocated flush did not use address as real");
    xlate_load_a : assert property ( // [R10]
        exec_flush_s ##0 s.data_relocate_bit |=> o_xl_req && o_xl_load && !o_lk_req)
        else $error("relocated flush did not request a load translation");
    dsi_fault_a : assert property ( // [R13]
        xl_fault_s |=> s.stat[`CLM_ST_DSI] && s.dsisr[`CLM_DSISR_FIRST] && !o_gpr_we
                       ##1 !o_lk_req)
        else $error("missing translation not reported");
    base_update_a : assert property ( // [R8]
        lk_done_s ##0 base_nz |=> o_gpr_we && (o_gpr_data == o_xl_addr))
        else $error("base register not updated");
    write_back_a : assert property ( // [R11]
        lk_done_s ##0 i_lk.dc_hit && i_lk.dc_dirty && !s.xl_bad |=> o_wb_start ##1 !o_wb_start)
        else $error("modified line not written back");
    invalidate_a : assert property ( // [R12]
        lk_done_s ##0 !s.xl_bad |=> o_inval == $past(i_lk.dc_hit | i_lk.ic_hit))
        else $error("line invalidate wrong");
    mach_check_a : assert property ( // [R14]
        lk_done_s ##0 s.xl_bad && i_lk.dc_hit |=> s.stat[`CLM_ST_MCK] && !o_inval)
        else $error("machine check not raised");
    ref_bit_a : assert property ( // [R16]
        (s.st == clm_pkg::ST_XLATE) && i_xl.ack && i_xl.valid
        |=> o_ref_set == $past(i_xl.tlb_miss))
        else $error("reference bit request wrong");
    io_noop_a : assert property ( // [R17]
        (s.st == clm_pkg::ST_EXEC) && is_flush && io_c
        |=> !o_xl_req && !o_lk_req && (o_gpr_we == $past(base_nz)) ##1 !o_inval)
        else $error("I/O flush touched the caches");
    xlate_kind_a : assert property ( // [R15]
        o_xl_req |-> o_xl_load)
        else $error("translation not requested as a load");
    ref_pulse_a : assert property ( // [R16]
        o_ref_set |=> !o_ref_set)
        else $error("reference bit request held too long");
endmodule : cache_line_maint
`default_nettype wire

// file: sim/xlate_mem_model.sv
`timescale 1ns/10ps
`default_nettype none

module xlate_mem_model (
    input  wire logic                   i_mclk,
    input  wire logic                   i_rst,
    input  wire logic                   i_xl_req,
    input  wire logic                   i_lk_req,
    input  wire logic [31:0]            i_xl_addr,
    input  wire logic [3:0]             i_dly,
    input  wire logic [5:0]             i_mode,
    output var  clm_pkg::xlate_rsp_type o_xl,
    output var  clm_pkg::cache_rsp_type o_lk
);
    logic [3:0] cnt_r;
    logic       xa_r;
    logic       la_r;

    // ==========
    // Answer i_dly+1 cycles after a request; ack lasts one cycle
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r <= 4'h0;
            xa_r  <= 1'b0;
            la_r  <= 1'b0;
        end else begin
            cnt_r <= ((i_xl_req || i_lk_req) && !xa_r && !la_r) ? cnt_r + 4'h1 : 4'h0;
            xa_r  <= i_xl_req && !xa_r && (cnt_r == i_dly);
            la_r  <= i_lk_req && !la_r && (cnt_r == i_dly);
        end
    end

    // Off the ack cycle the fields carry noise, so a stale answer is never seen
    always_comb begin
        o_xl.ack      = xa_r;
        o_xl.valid    = xa_r ? !i_mode[0] : cnt_r[0];
        o_xl.tlb_miss = xa_r ? i_mode[1] : cnt_r[1];
        o_xl.real_bad = xa_r ? i_mode[2] : cnt_r[2];
        o_xl.raddr    = i_xl_addr ^ 32'h8000_0000 ^ (xa_r ? 32'h0 : {8{cnt_r | 4'h1}});
        o_lk.ack      = la_r;
        o_lk.dc_hit   = la_r ? i_mode[3] : cnt_r[0];
        o_lk.dc_dirty = la_r ? i_mode[4] : cnt_r[1];
        o_lk.ic_hit   = la_r ? i_mode[5] : cnt_r[2];
    end
endmodule : xlate_mem_model
`default_nettype wire

// file: sim/cache_line_maint_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "clm_consts.svh"

module cache_line_maint_tb;
    localparam logic [31:0] ILINE = 32'h0000_0100;
    localparam logic [31:0] DLINE = 32'h0000_0040;
    logic        i_mclk  = 1'b0;
    logic        i_rst   = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [3:0]  dly     = 4'h0;
    logic [5:0]  mode    = 6'h00;
    logic [31:0] prdata, xl_addr, lk_addr, gpr_data, q;
    logic [4:0]  gpr_idx;
    logic        pready, pslverr, irq, xl_req, xl_load, lk_req, wb, inv, refs, gpr_we, err;
    clm_pkg::xlate_rsp_type xl;
    clm_pkg::cache_rsp_type lk;
    logic [36:0] gpr_q[$];
    logic [34:0] act_q[$];
    logic [31:0] sz[4] = '{ILINE, DLINE, DLINE, ILINE};
    logic [11:0] ra_l[6] = '{12'h000, 12'h010, 12'h014, 12'h018, 12'h01c, 12'h020};
    int          n_fail    = 0;
    int          tests_run = 0;

    always #2.5 i_mclk = ~i_mclk;

    cache_line_maint #(.ILINE(ILINE), .DLINE(DLINE)) DUT (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq), .o_xl_req(xl_req),
        .o_xl_load(xl_load), .o_xl_addr(xl_addr), .i_xl(xl), .o_lk_req(lk_req),
        .o_lk_addr(lk_addr), .i_lk(lk), .o_wb_start(wb), .o_inval(inv), .o_ref_set(refs),
        .o_gpr_we(gpr_we), .o_gpr_idx(gpr_idx), .o_gpr_data(gpr_data));

    xlate_mem_model far_end (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_xl_req(xl_req), .i_lk_req(lk_req),
        .i_xl_addr(xl_addr), .i_dly(dly), .i_mode(mode), .o_xl(xl), .o_lk(lk));

    // ==========
    // Checking and closing
    task automatic chk(input string nm, input logic [36:0] e, input logic [36:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done

    always @(posedge i_mclk) begin
        if (gpr_we === 1'b1) begin
            if (gpr_q.size() == 0) chk("gpr write", 37'h0, 37'h1);
            else chk("gpr write", gpr_q.pop_front(), {gpr_idx, gpr_data});
        end
        if ((wb | inv | refs) === 1'b1) begin
            if (act_q.size() == 0) chk("line action", 37'h0, 37'h1);
            else chk("line action", 37'(act_q.pop_front()), 37'({refs, wb, inv, lk_addr}));
        end
    end

    // ==========
    // Bus and instruction helpers
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge i_mclk);
        penable <= 1'b1;
        do begin
            @(posedge i_mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q       = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_fail++;
            test_done();
        end
    endtask : apb

    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, `CLM_OFF_STATUS, 32'h0);
            n++;
        end while (q[`CLM_ST_BUSY] !== 1'b0 && n < 40);
        if (q[`CLM_ST_BUSY] !== 1'b0) begin
            n_fail++;
            test_done();
        end
    endtask : wait_idle

    function automatic logic [31:0] mk(input logic [5:0] op, input logic [9:0] xo,
                                       input logic [4:0] t, a, b, input logic rc);
        clm_pkg::instr_type w;
        w = '{op: op, target_reg_field: t, base_reg_field: a, index_reg_field: b,
              xo: xo, record_bit: rc};
        return w;
    endfunction : mk

    task automatic flush(input string nm, input logic dr, io, input logic [4:0] ra,
                         input logic [5:0] md, input logic [3:0] dl, input logic poke);
        logic [31:0] opa, opb, ea, rl;
        logic        dsi, mck;
        opa  = $urandom;
        opb  = $urandom;
        ea   = (ra == 5'h0) ? opb : opa + opb;
        dsi  = dr && !io && md[0];
        mck  = dr && !io && !md[0] && md[2] && md[3];
        rl   = dr ? ea ^ 32'h8000_0000 : ea;
        mode <= md;
        dly  <= dl;
        if (dr && !io && !md[0] && md[1]) act_q.push_back({3'b100, rl});
        if (!io && !dsi && !mck && (md[3] || md[5]))
            act_q.push_back({1'b0, md[3] && md[4], 1'b1, rl});
        if (ra != 5'h0 && !dsi) gpr_q.push_back({ra, ea});
        apb(1'b1, `CLM_OFF_CTRL, {24'h0, ea[31:28] + {3'h0, !io}, 2'h0, opa[0], dr});
        apb(1'b1, `CLM_OFF_OPA, opa);
        apb(1'b1, `CLM_OFF_OPB, opb);
        apb(1'b1, `CLM_OFF_STATUS, 32'h7);
        apb(1'b1, `CLM_OFF_DSISR, 32'h0);
        apb(1'b1, `CLM_OFF_INSTR,
            mk(`CLM_OP_PRIMARY, `CLM_XO_FLUSH, 5'($urandom), ra, 5'($urandom), 1'b1));
        if (poke) apb(1'b1, `CLM_OFF_INSTR,
                      mk(`CLM_OP_PRIMARY, `CLM_XO_QUERY, 5'h1, `CLM_SEL_MAX, 5'h0, 1'b0));
        wait_idle();
        chk("fault bits", 37'({mck, dsi}), 37'(q[2:1]));
        apb(1'b0, dsi ? `CLM_OFF_DSISR : `CLM_OFF_EA, 32'h0);
        chk("dsisr or ea", 37'(dsi ? 32'h8000_0000 : ea), 37'(q));
        $display("test %s done", nm);
    endtask : flush

    task automatic irq_step(input logic [11:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        repeat (2) @(posedge i_mclk);
        chk("irq", 37'(e), 37'(irq));
    endtask : irq_step

    // ==========
    // Main sequence
    initial begin
        logic [4:0] t;
        void'($urandom(77));
        repeat (5) @(posedge i_mclk);
        i_rst <= 1'b0;
        foreach (ra_l[i]) begin
            apb(1'b0, ra_l[i], 32'h0);
            chk("reset value", 37'h0, 37'({err, q}));
        end
        apb(1'b1, 12'h0f0, 32'hffff_ffff);
        apb(1'b0, 12'h0f0, 32'h0);
        chk("unmapped", 37'h1_0000_0000, 37'({err, q}));
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            t = 5'($urandom);
            gpr_q.push_back({t, sz[i]});
            apb(1'b1, `CLM_OFF_INSTR, mk(`CLM_OP_PRIMARY, `CLM_XO_QUERY, t,
                                         `CLM_SEL_ICACHE + 5'(i), 5'h0, 1'(i)));
            wait_idle();
            apb(1'b0, `CLM_OFF_RESULT, 32'h0);
            chk("result", 37'(sz[i]), 37'(q));
        end
        apb(1'b1, `CLM_OFF_INSTR, mk(6'h1e, `CLM_XO_QUERY, 5'h4, `CLM_SEL_MAX, 5'h0, 1'b0));
        wait_idle();
        apb(1'b1, `CLM_OFF_INSTR, mk(`CLM_OP_PRIMARY, 10'h214, 5'h4, `CLM_SEL_MAX, 5'h0, 1'b0));
        wait_idle();
        $display("test query done");
        flush("real dirty", 1'b0, 1'b0, 5'h03, 6'b011000, 4'h0, 1'b0);
        flush("base zero", 1'b0, 1'b0, 5'h00, 6'b100000, 4'h2, 1'b0);
        flush("xlate miss", 1'b1, 1'b0, 5'h07, 6'b101010, 4'h8, 1'b1);
        flush("mcheck", 1'b1, 1'b0, 5'h1f, 6'b011100, 4'h1, 1'b0);
        flush("io space", 1'b1, 1'b1, 5'h02, 6'b111111, 4'h0, 1'b0);
        flush("no xlate", 1'b1, 1'b0, 5'h09, 6'b000001, 4'h3, 1'b0);
        irq_step(`CLM_OFF_MASK, 32'h0, 1'b0);
        irq_step(`CLM_OFF_MASK, 32'h2, 1'b1);
        irq_step(`CLM_OFF_STATUS, 32'h2, 1'b0);
        $display("test irq done");
        repeat (20) @(posedge i_mclk);
        chk("pending", 37'h0, 37'(gpr_q.size() + act_q.size()));
        test_done();
    end
endmodule : cache_line_maint_tb
`default_nettype wire
